// file: hdl/sbs_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Included by bare name
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_ADDR_BAUD 4'h0
`define SBS_ADDR_CTRL 4'h4
`define SBS_ADDR_STAT 4'h8
`define SBS_ADDR_DATA 4'hC

`define SBS_BAUD_RATE_LSB 0
`define SBS_BAUD_PRE_LSB 4

`define SBS_CTRL_TXEN 0
`define SBS_CTRL_TIE 1
`define SBS_CTRL_TX_DONE_IRQ_ENABLE 2
`define SBS_CTRL_RIE 3
`define SBS_CTRL_ILIE 4
`define SBS_CTRL_WAKE 5

`define SBS_ST_PINOWN 8
`define SBS_ST_TX_BUFFER_EMPTY_FLAG 7
`define SBS_ST_TC 6
`define SBS_ST_RX_BUFFER_FULL_FLAG 5
`define SBS_ST_IDLE 4
`define SBS_ST_OVR 3
`define SBS_ST_NF 2
`define SBS_ST_FE 1

`define SBS_PRE_RESET 3'h0

`define SBS_PRE_DIV_1 6'h01
`define SBS_PRE_DIV_3 6'h03
`define SBS_PRE_DIV_4 6'h04
`define SBS_PRE_DIV_13 6'h0D
`define SBS_PRE_DIV_39 6'h27

`define SBS_RT_PER_BIT 4'hF
`define SBS_CHAR_BITS 10
`define SBS_CHAR_TICKS 160

`endif

// file: hdl/sbs_pkg.sv
// Purpose: Types shared by the serial baud and status block
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Constants live in sbs_map.svh
package sbs_pkg;

	typedef enum logic {
		SBS_TX_IDLE = 1'b0,
		SBS_TX_SHIFT = 1'b1
	} sbs_tx_state_t;

	typedef struct packed {
		logic [5:0] preCnt;
		logic [6:0] rateCnt;
		logic [3:0] bitCnt;
		logic rtTick;
		logic bitTick;
	} sbs_baud_t;

	typedef struct packed {
		logic [2:0] rateSel;
		logic [2:0] preSel;
		logic txEn;
		logic tieEn;
		logic tcieEn;
		logic rieEn;
		logic ilieEn;
		logic wakeup;
		logic tx_buffer_empty_flag;
		logic tc;
		logic rx_buffer_full_flag;
		logic idle;
		logic ovr;
		logic nf;
		logic fe;
		logic [1:0] armTx;
		logic [4:0] armRx;
		logic holdFull;
		logic [7:0] holdData;
		logic [7:0] rxHold;
		sbs_tx_state_t txState;
		logic [9:0] txShift;
		logic [3:0] txCnt;
		logic pinOwn;
		logic busySeen;
		logic [7:0] idleCnt;
		logic rxS1;
		logic rxS2;
		logic ack;
		logic [31:0] rdData;
	} sbs_core_t;

endpackage

// file: hdl/sbs_baud_gen.sv
// Purpose: Prescaler, binary rate divider and divide-by-16 chain
// Assumes: Selects come from registers on the same clock
// Notes: Both ticks are one-cycle enables from flip-flops
`timescale 1ns/1ps
`include "sbs_map.svh"
module sbs_baud_gen
	import sbs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] preSel,
	input wire logic [2:0] rateSel,
	output logic rtTick,
	output logic bitTick
);

	sbs_baud_t st_q;
	sbs_baud_t st_d;
	logic [5:0] preDiv;
	logic [6:0] rateMask;
	logic preTick;
	logic rateTick;

	always_comb begin
		case (preSel)
			3'h0: preDiv = `SBS_PRE_DIV_1;
			3'h1: preDiv = `SBS_PRE_DIV_3;
			3'h2: preDiv = `SBS_PRE_DIV_4;
			3'h3: preDiv = `SBS_PRE_DIV_13;
			3'h4: preDiv = `SBS_PRE_DIV_39;
			default: preDiv = `SBS_PRE_DIV_1;
		endcase
	end

	assign preTick = (st_q.preCnt == preDiv - 6'h01);
	assign rateMask = 7'((8'h01 << rateSel) - 8'h01);
	assign rateTick = preTick && ((st_q.rateCnt & rateMask) == rateMask);

	always_comb begin
		st_d = st_q;
		st_d.rtTick = 1'b0;
		st_d.bitTick = 1'b0;
		st_d.preCnt = preTick ? 6'h00 : st_q.preCnt + 6'h01;
		if (preTick) begin
			st_d.rateCnt = st_q.rateCnt + 7'h01;
		end
		if (rateTick) begin
			st_d.rtTick = 1'b1;
			st_d.bitCnt = st_q.bitCnt + 4'h1;
			st_d.bitTick = (st_q.bitCnt == `SBS_RT_PER_BIT);
		end
		if (!rst_b) begin
			st_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign rtTick = st_q.rtTick;
	assign bitTick = st_q.bitTick;

endmodule

// file: hdl/sbs_serial_core.sv
// Purpose: Serial port baud control, transmitter and status flags
// Assumes: Receive shifter outside hands over whole characters
// Notes: Avalon-MM slave, one wait state on every access
// Overview of operation
// - prescale code picks divide 1,3,4,13,39
// - rate code divides further by powers two
// - divider chain output is 16x sample clock
// - bit clock is sample clock divided 16
// - rate bits survive reset, writable any time
// - hardware sets flags, software sequence clears
// - enabling transmitter sets empty and done
// - empty flag with enable requests interrupt
// - done flag with enable requests interrupt
// - disabling transmitter finishes current character
// - idle disable returns pin on bit clock
// - mid-character disable drops queue, sets flags
// - overrun keeps held character, sets overrun
// - received character moved sets buffer full
// - noise and stop error never interrupt
// - idle flag after busy then character-time high
// - five receive flags, three may interrupt
// - status read then data write clears tx
// - status read then data read clears rx
// - reset sets prescaler to divide by one
// - wakeup mode inhibits idle flag
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "sbs_map.svh"
module sbs_serial_core
	import sbs_pkg::*;
#(
	parameter int IDLE_TICKS = `SBS_CHAR_TICKS
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxdPin,
	input wire logic rxCharValid,
	input wire logic [7:0] rxChar,
	input wire logic rxNoise,
	input wire logic rxStopErr,
	output logic rxSampleTick,
	output logic txdPin,
	output logic txdOe,
	output logic irq
);

	generate
		if (IDLE_TICKS < 2 || IDLE_TICKS > 255) begin : gBadIdle
			$error("IDLE_TICKS must lie in 2..255");
		end
	endgenerate

	localparam logic [7:0] IDLE_LAST = 8'(IDLE_TICKS - 1);

	sbs_core_t st_q;
	sbs_core_t st_d;
	logic rtTick;
	logic bitTick;
	logic req;
	logic accept;
	logic wrLow;
	logic [31:0] rd;
	logic [1:0] clrTx;
	logic [4:0] clrRx;

	sbs_baud_gen i_sbs_baud_gen (
		.clk(clk),
		.rst_b(rst_b),
		.preSel(st_q.preSel),
		.rateSel(st_q.rateSel),
		.rtTick(rtTick),
		.bitTick(bitTick)
	);

	assign req = avs_read | avs_write;
	assign accept = req & st_q.ack;
	assign wrLow = accept & avs_write & avs_byteenable[0];

	// Read data snapshot taken in the wait cycle
	always_comb begin
		rd = '0;
		case (avs_address)
			`SBS_ADDR_BAUD: begin
				rd[`SBS_BAUD_RATE_LSB +: 3] = st_q.rateSel;
				rd[`SBS_BAUD_PRE_LSB +: 3] = st_q.preSel;
			end
			`SBS_ADDR_CTRL: begin
				rd[`SBS_CTRL_TXEN] = st_q.txEn;
				rd[`SBS_CTRL_TIE] = st_q.tieEn;
				rd[`SBS_CTRL_TX_DONE_IRQ_ENABLE] = st_q.tcieEn;
				rd[`SBS_CTRL_RIE] = st_q.rieEn;
				rd[`SBS_CTRL_ILIE] = st_q.ilieEn;
				rd[`SBS_CTRL_WAKE] = st_q.wakeup;
			end
			`SBS_ADDR_STAT: begin
				rd[`SBS_ST_PINOWN] = st_q.pinOwn;
				rd[`SBS_ST_TX_BUFFER_EMPTY_FLAG] = st_q.tx_buffer_empty_flag;
				rd[`SBS_ST_TC] = st_q.tc;
				rd[`SBS_ST_RX_BUFFER_FULL_FLAG] = st_q.rx_buffer_full_flag;
				rd[`SBS_ST_IDLE] = st_q.idle;
				rd[`SBS_ST_OVR] = st_q.ovr;
				rd[`SBS_ST_NF] = st_q.nf;
				rd[`SBS_ST_FE] = st_q.fe;
			end
			`SBS_ADDR_DATA: begin
				rd[7:0] = st_q.rxHold;
			end
			default: begin
				rd = '0;
			end
		endcase
	end

	// Flags armed by a status read, consumed by the data access
	assign clrTx = (wrLow && avs_address == `SBS_ADDR_DATA) ?
		st_q.armTx : 2'h0;
	assign clrRx = (accept && avs_read && avs_address == `SBS_ADDR_DATA) ?
		st_q.armRx : 5'h00;

	always_comb begin
		st_d = st_q;
		st_d.rxS1 = rxdPin;
		st_d.rxS2 = st_q.rxS1;
		st_d.ack = req & ~st_q.ack;
		if (req && !st_q.ack) begin
			st_d.rdData = rd;
		end

		// Clears first so any set below wins
		if (clrTx[1]) st_d.tx_buffer_empty_flag = 1'b0;
		if (clrTx[0]) st_d.tc = 1'b0;
		if (clrRx[4]) st_d.rx_buffer_full_flag = 1'b0;
		if (clrRx[3]) st_d.idle = 1'b0;
		if (clrRx[2]) st_d.ovr = 1'b0;
		if (clrRx[1]) st_d.nf = 1'b0;
		if (clrRx[0]) st_d.fe = 1'b0;
		if (clrTx != 2'h0) st_d.armTx = 2'h0;
		if (clrRx != 5'h00) st_d.armRx = 5'h00;

		if (accept && avs_read && avs_address == `SBS_ADDR_STAT) begin
			st_d.armTx = {st_q.rdData[`SBS_ST_TX_BUFFER_EMPTY_FLAG],
				st_q.rdData[`SBS_ST_TC]};
			st_d.armRx = {st_q.rdData[`SBS_ST_RX_BUFFER_FULL_FLAG],
				st_q.rdData[`SBS_ST_IDLE], st_q.rdData[`SBS_ST_OVR],
				st_q.rdData[`SBS_ST_NF], st_q.rdData[`SBS_ST_FE]};
		end

		if (wrLow) begin
			case (avs_address)
				`SBS_ADDR_BAUD: begin
					st_d.rateSel = avs_writedata[`SBS_BAUD_RATE_LSB +: 3];
					st_d.preSel = avs_writedata[`SBS_BAUD_PRE_LSB +: 3];
				end
				`SBS_ADDR_CTRL: begin
					st_d.txEn = avs_writedata[`SBS_CTRL_TXEN];
					st_d.tieEn = avs_writedata[`SBS_CTRL_TIE];
					st_d.tcieEn = avs_writedata[`SBS_CTRL_TX_DONE_IRQ_ENABLE];
					st_d.rieEn = avs_writedata[`SBS_CTRL_RIE];
					st_d.ilieEn = avs_writedata[`SBS_CTRL_ILIE];
					st_d.wakeup = avs_writedata[`SBS_CTRL_WAKE];
					if (avs_writedata[`SBS_CTRL_TXEN] && !st_q.txEn) begin
						st_d.tx_buffer_empty_flag = 1'b1;
						st_d.tc = 1'b1;
					end
				end
				`SBS_ADDR_DATA: begin
					if (st_q.txEn) begin
						st_d.holdFull = 1'b1;
						st_d.holdData = avs_writedata[7:0];
					end
				end
				default: begin
					st_d.holdFull = st_d.holdFull;
				end
			endcase
		end

		// Transmit sequencing on the bit-rate clock
		if (bitTick) begin
			st_d.pinOwn = st_q.txEn | (st_q.txState == SBS_TX_SHIFT);
			case (st_q.txState)
				SBS_TX_IDLE: begin
					if (st_q.holdFull && st_q.txEn) begin
						st_d.txShift = {1'b1, st_q.holdData, 1'b0};
						st_d.txCnt = 4'h0;
						st_d.holdFull = 1'b0;
						st_d.tx_buffer_empty_flag = 1'b1;
						st_d.txState = SBS_TX_SHIFT;
						st_d.pinOwn = 1'b1;
					end
				end
				SBS_TX_SHIFT: begin
					st_d.txShift = {1'b1, st_q.txShift[9:1]};
					st_d.txCnt = st_q.txCnt + 4'h1;
					if (st_q.txCnt == 4'(`SBS_CHAR_BITS - 1)) begin
						st_d.txState = SBS_TX_IDLE;
						if (!st_q.txEn) begin
							st_d.holdFull = 1'b0;
							st_d.tx_buffer_empty_flag = 1'b1;
							st_d.tc = 1'b1;
						end else if (!st_d.holdFull) begin
							st_d.tc = 1'b1;
						end
					end
				end
				default: begin
					st_d.txState = SBS_TX_IDLE;
				end
			endcase
		end

		// Character handed over by the receive shifter
		if (rxCharValid) begin
			if (st_d.rx_buffer_full_flag) begin
				st_d.ovr = 1'b1;
			end else begin
				st_d.rxHold = rxChar;
				st_d.rx_buffer_full_flag = 1'b1;
				st_d.nf = rxNoise;
				st_d.fe = rxStopErr;
			end
		end

		// Idle line: one character time of ones after activity
		if (rtTick) begin
			if (!st_q.rxS2) begin
				st_d.idleCnt = 8'h00;
				st_d.busySeen = 1'b1;
			end else if (st_q.idleCnt < IDLE_LAST) begin
				st_d.idleCnt = st_q.idleCnt + 8'h01;
			end else if (st_q.busySeen) begin
				st_d.busySeen = 1'b0;
				if (!st_q.wakeup) begin
					st_d.idle = 1'b1;
				end
			end
		end

		if (!rst_b) begin
			st_d = '0;
			st_d.rateSel = st_q.rateSel;
			st_d.preSel = `SBS_PRE_RESET;
			st_d.txShift = '1;
			st_d.rxS1 = 1'b1;
			st_d.rxS2 = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign avs_waitrequest = req & ~st_q.ack;
	assign avs_readdata = st_q.rdData;
	assign rxSampleTick = rtTick;
	assign txdPin = st_q.txShift[0];
	assign txdOe = st_q.pinOwn;

	// Per-source requests, merged onto one line
	logic txEmptyReq;
	logic txDoneReq;
	logic rxDataReq;
	logic rxIdleReq;

	assign txEmptyReq = st_q.tx_buffer_empty_flag & st_q.tieEn;
	assign txDoneReq = st_q.tc & st_q.tcieEn;
	// Noise and stop error stay out of the request
	assign rxDataReq = (st_q.rx_buffer_full_flag | st_q.ovr) & st_q.rieEn;
	assign rxIdleReq = st_q.idle & st_q.ilieEn;
	assign irq = txEmptyReq | txDoneReq | rxDataReq | rxIdleReq;

endmodule

// file: bench/sbs_serial_core_checker.sv
// Purpose: Port checks for the serial core
// Assumes: One clock, reset low active
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module sbs_serial_core_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic txdPin,
	input wire logic txdOe,
	input wire logic irq
);
	logic lastQ;
	logic [4:0] runQ;
	wire rdOk = avs_read && !avs_waitrequest;
	wire ctlWr = avs_write && !avs_waitrequest && avs_address == 4'h4
		&& avs_byteenable[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles the tx pin has held its level
	always_ff @(posedge clk) begin
		lastQ <= txdPin;
		if (!rst_b || txdPin != lastQ)
			runQ <= 5'h00;
		else if (runQ != 5'h1F)
			runQ <= runQ + 5'h01;
	end
	wait_one_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	unmapped_zero_a: assert property (
		rdOk && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	status_pad_a: assert property (
		rdOk && avs_address == 4'h8 |->
		avs_readdata[31:9] == 23'h0 && !avs_readdata[0])
		else $error("status spare bits set");
	pin_idle_a: assert property (!txdOe |-> txdPin)
		else $error("released pin not high");
	start_owned_a: assert property (!txdPin |-> txdOe)
		else $error("low pin while not owned");
	bit_hold_a: assert property (txdPin != lastQ |-> runQ >= 5'h0F)
		else $error("tx bit shorter than 16 clocks");
	tx_irq_a: assert property (
		ctlWr && avs_writedata[0] && avs_writedata[2:1] != 2'h0 |=> irq)
		else $error("no request after tx enable");
	irq_off_a: assert property (
		ctlWr && avs_writedata[4:1] == 4'h0 |=> !irq)
		else $error("request with all enables off");
endmodule

// file: bench/sbs_line_model.sv
// Purpose: Remote station on the serial line
// Assumes: Bit length fixed at 16 clocks, matching the fastest baud the bench uses
// Notes: Receive side hands whole chars to the core
`timescale 1ns/1ps
module sbs_line_model (
	input wire logic clk,
	input wire logic txdPin,
	output logic rxdPin,
	output logic rxCharValid,
	output logic [7:0] rxChar,
	output logic rxNoise,
	output logic rxStopErr
);
	int bitLen = 16;
	int frames = 0;
	logic [9:0] lastFrame;
	initial begin
		rxdPin = 1'b1;
		rxCharValid = 1'b0;
		rxChar = 8'h00;
		rxNoise = 1'b0;
		rxStopErr = 1'b0;
	end
	// Sample each tx bit in its middle
	always begin
		@(negedge txdPin);
		repeat (bitLen / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			lastFrame[i] = txdPin;
			repeat (bitLen) @(posedge clk);
		end
		frames++;
	end
	task automatic sendChar(input logic [7:0] c, input logic n, input logic s);
		@(posedge clk);
		rxdPin <= 1'b0;
		repeat (bitLen * 9) @(posedge clk);
		rxdPin <= 1'b1;
		rxCharValid <= 1'b1;
		rxChar <= c;
		rxNoise <= n;
		rxStopErr <= s;
		@(posedge clk);
		// Stale strobe data must not look valid
		rxCharValid <= 1'b0;
		rxChar <= ~c;
		rxNoise <= ~n;
		rxStopErr <= ~s;
	endtask
endmodule

// file: bench/sbs_serial_core_bench.sv
// Purpose: Self-checking bench for the serial core
// Assumes: Fastest baud for traffic, short idle time
// Notes: Read results are matched against a queue
`timescale 1ns/1ps
module sbs_serial_core_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rdEn = 1'b0;
	logic wrEn = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wreq, rxd, rxv, rxn, rxs, rtk, txd, txOe, irq;
	logic [7:0] rxc;
	logic [31:0] seed = 32'h00006608;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];
	int numErrors = 0;
	int cmpCount = 0;
	int pd[5] = '{1, 3, 4, 13, 39};
	always #50 clk = ~clk;
	sbs_serial_core #(.IDLE_TICKS(20)) i_sbs_serial_core (.clk(clk),
		.rst_b(rst_b), .avs_address(adr), .avs_read(rdEn),
		.avs_write(wrEn), .avs_writedata(wdat), .avs_byteenable(4'hF),
		.avs_readdata(rdat), .avs_waitrequest(wreq), .rxdPin(rxd),
		.rxCharValid(rxv), .rxChar(rxc), .rxNoise(rxn), .rxStopErr(rxs),
		.rxSampleTick(rtk), .txdPin(txd), .txdOe(txOe), .irq(irq));
	sbs_line_model i_sbs_line_model (.clk(clk), .txdPin(txd), .rxdPin(rxd),
		.rxCharValid(rxv), .rxChar(rxc), .rxNoise(rxn), .rxStopErr(rxs));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic endSim();
		$display("errors=%0d compares=%0d", numErrors, cmpCount);
		if (numErrors == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic busOp(input logic r, input logic [3:0] a,
		input logic [31:0] d);
		adr <= a;
		wdat <= d;
		rdEn <= r;
		wrEn <= !r;
		do @(posedge clk); while (wreq);
		rdEn <= 1'b0;
		wrEn <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		busOp(1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		busOp(1'b1, a, 32'h0);
	endtask
	task automatic period(input logic [31:0] exp);
		logic [31:0] n;
		n = 32'h0;
		repeat (2) @(posedge clk iff rtk);
		do begin
			@(posedge clk);
			n++;
		end while (!rtk);
		cmp(n, exp);
	endtask
	// Oldest queued expectation meets each accepted read
	always @(posedge clk) begin
		if (rdEn && !wreq) begin
			cmp(rdat & mskQ[0], expQ.pop_front());
			void'(mskQ.pop_front());
		end
	end
	initial begin
		logic [7:0] c;
		int f;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(4'h8, 32'h0, 32'h1FE);
		wr(4'h0, 32'h13);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(4'h0, 32'h03, 32'h77);
		rd(4'h6, 32'h0, 32'hFFFFFFFF);
		cmp(irq, 1'b0);
		cmp(txOe, 1'b0);
		for (int p = 0; p < 5; p++) begin
			for (int r = 0; r < 8; r++) begin
				wr(4'h0, 32'(p * 16 + r));
				period(32'(pd[p] << r));
			end
		end
		wr(4'h0, 32'h0);
		wr(4'h4, 32'h03);
		cmp(irq, 1'b1);
		wr(4'h4, 32'h00);
		wr(4'h4, 32'h05);
		cmp(irq, 1'b1);
		wr(4'h4, 32'h00);
		wr(4'h4, 32'h01);
		rd(4'h8, 32'hC0, 32'hC0);
		c = 8'(rnd());
		f = i_sbs_line_model.frames;
		wr(4'hC, 32'(c));
		rd(4'h8, 32'h0, 32'h40);
		while (i_sbs_line_model.frames == f) @(posedge clk);
		cmp(i_sbs_line_model.lastFrame, {1'b1, c, 1'b0});
		rd(4'h8, 32'hC0, 32'hC0);
		f = i_sbs_line_model.frames;
		wr(4'hC, 32'(c));
		while (txd) @(posedge clk);
		wr(4'hC, 32'(~c));
		wr(4'h4, 32'h00);
		repeat (320) @(posedge clk);
		cmp(i_sbs_line_model.frames, f + 1);
		cmp(txOe, 1'b0);
		rd(4'h8, 32'hC0, 32'h1C0);
		c = 8'(rnd());
		i_sbs_line_model.sendChar(c, 1'b1, 1'b0);
		rd(4'h8, 32'h24, 32'h2E);
		cmp(irq, 1'b0);
		wr(4'h4, 32'h08);
		cmp(irq, 1'b1);
		i_sbs_line_model.sendChar(~c, 1'b0, 1'b1);
		rd(4'h8, 32'h2C, 32'h2E);
		rd(4'hC, 32'(c), 32'hFF);
		rd(4'h8, 32'h0, 32'h2E);
		repeat (40) @(posedge clk);
		rd(4'h8, 32'h10, 32'h10);
		rd(4'hC, 32'(c), 32'hFF);
		repeat (40) @(posedge clk);
		rd(4'h8, 32'h0, 32'h10);
		wr(4'h4, 32'h20);
		i_sbs_line_model.sendChar(c, 1'b0, 1'b0);
		repeat (40) @(posedge clk);
		rd(4'h8, 32'h0, 32'h10);
		endSim();
	end
	initial begin
		repeat (80000) @(posedge clk);
		numErrors++;
		endSim();
	end
endmodule
bind sbs_serial_core sbs_serial_core_checker i_sbs_serial_core_checker (
	.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.txdPin(txdPin), .txdOe(txdOe), .irq(irq));
